// >>> shared/rate_select_pkg.sv
// Purpose: constants shared by the bit-rate source select block
// Assumes: 32-bit apb data, one register per aligned word
// Notes: generator table is indexed by {set, extend, nibble}
package rate_select_pkg;
  // clock of the block
  localparam int REF_CLK_PERIOD_NS = 50;
  // apb map
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [7:0] OFS_CMD_A = 8'h00;
  localparam logic [7:0] OFS_CMD_B = 8'h04;
  localparam logic [7:0] OFS_AUX = 8'h08;
  localparam logic [7:0] OFS_CSEL_A = 8'h0C;
  localparam logic [7:0] OFS_CSEL_B = 8'h10;
  localparam logic [7:0] OFS_TMR_UP = 8'h14;
  localparam logic [7:0] OFS_TMR_LO = 8'h18;
  localparam logic [7:0] OFS_OPCFG = 8'h1C;
  localparam logic [7:0] OFS_SYSCFG = 8'h20;
  localparam logic [7:0] OFS_STATUS = 8'h24;
  // reset values
  localparam logic [7:0] REG8_RST = 8'h00;
  // channel command codes
  localparam logic [7:0] CMD_SET_RX_EXT = 8'h08;
  localparam logic [7:0] CMD_CLR_RX_EXT = 8'h09;
  localparam logic [7:0] CMD_SET_TX_EXT = 8'h0A;
  localparam logic [7:0] CMD_CLR_TX_EXT = 8'h0B;
  // aux control fields
  localparam int AUX_SET_BIT = 7;
  localparam int AUX_MODE_HI = 6;
  localparam int AUX_MODE_LO = 4;
  localparam logic [2:0] MODE_TIMER_REF = 3'h6;
  // output pin config fields
  localparam int OPCFG_HI = 3;
  localparam int OPCFG_LO = 2;
  localparam logic [1:0] OPCFG_TIMER = 2'h1;
  // system config fields
  localparam int SYSCFG_HALVE = 0;
  localparam int SYSCFG_GP_OUT = 1;
  // status fields
  localparam int STAT_EXT_LO = 0;
  localparam int STAT_TIMER = 4;
  localparam int STAT_PIN_LO = 5;
  // clock-select nibble codes
  localparam logic [3:0] NIB_BRG_LAST = 4'hC;
  localparam logic [3:0] NIB_TIMER = 4'hD;
  localparam logic [3:0] NIB_EXT_16X = 4'hE;
  localparam logic [3:0] NIB_EXT_1X = 4'hF;
  // oversample counter
  localparam int OVS_W = 4;
  localparam logic [3:0] OVS_LAST = 4'hF;
  // generator divisors, reference edges per 16x tick
  localparam int BRG_DIV_W = 13;
  localparam int BRG_CNT_W = 14;
  localparam logic [12:0] BRG_DIV [0:63] = '{
    13'h1200, 13'h082E, 13'h06B1, 13'h0480, 13'h0300, 13'h0180, 13'h00C0, 13'h00DB,
    13'h0080, 13'h0073, 13'h0060, 13'h0018, 13'h000C, 13'h0001, 13'h0001, 13'h0001,
    13'h0C00, 13'h0600, 13'h06B1, 13'h0240, 13'h0100, 13'h0020, 13'h0040, 13'h006E,
    13'h0030, 13'h0028, 13'h0010, 13'h0008, 13'h0006, 13'h0001, 13'h0001, 13'h0001,
    13'h0C00, 13'h082E, 13'h06B1, 13'h0600, 13'h0300, 13'h0180, 13'h00C0, 13'h0080,
    13'h0060, 13'h0030, 13'h0020, 13'h0018, 13'h0004, 13'h0001, 13'h0001, 13'h0001,
    13'h0600, 13'h0480, 13'h0300, 13'h0120, 13'h0090, 13'h0048, 13'h0024, 13'h0012,
    13'h0002, 13'h0003, 13'h0018, 13'h000C, 13'h0060, 13'h0001, 13'h0001, 13'h0001
  };
  // apb slave states
  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_RESP = 1'b1
  } apb_state_e;
endpackage

// >>> rtl/rate_divider.sv
// Purpose: per-direction source select and divide to bit tick
// Assumes: all tick inputs are one-cycle pulses on i_ref_clk
// Notes: outputs are registered pulses
`timescale 1ns/1ps
module rate_divider
  import rate_select_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  input wire logic [3:0] i_sel,
  input wire logic [BRG_DIV_W-1:0] i_div,
  input wire logic i_halve,
  input wire logic i_ref_rise,
  input wire logic i_timer_rise,
  input wire logic i_ext_rise,
  output logic o_x16_tick,
  output logic o_bit_tick
);
  logic [BRG_CNT_W-1:0] brg_cnt; // reference edges seen
  logic [BRG_CNT_W-1:0] div_last; // last count of a period
  logic brg_tick; // generator 16x tick
  logic src_tick; // selected source tick
  logic direct; // source used as 1x
  logic [OVS_W-1:0] ovs_cnt; // divide by sixteen

  // divided mode doubles the period
  always_comb begin
    if (i_halve) begin
      div_last = {i_div, 1'b0} - BRG_CNT_W'(1);
    end else begin
      div_last = {1'b0, i_div} - BRG_CNT_W'(1);
    end
    brg_tick = i_ref_rise && (brg_cnt >= div_last);
    direct = (i_sel == NIB_EXT_1X);
  end

  // source select by nibble
  always_comb begin
    if (i_sel <= NIB_BRG_LAST) begin
      src_tick = brg_tick;
    end else if (i_sel == NIB_TIMER) begin
      src_tick = i_timer_rise;
    end else begin
      src_tick = i_ext_rise;
    end
  end

  // generator period counter
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      brg_cnt <= '0;
    end else if (brg_tick) begin
      brg_cnt <= '0;
    end else if (i_ref_rise) begin
      brg_cnt <= brg_cnt + 1'b1;
    end
  end

  // oversample counter, idle in 1x
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      ovs_cnt <= '0;
    end else if (direct) begin
      ovs_cnt <= '0;
    end else if (src_tick) begin
      ovs_cnt <= ovs_cnt + 1'b1;
    end
  end

  // registered tick outputs
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_x16_tick <= 1'b0;
      o_bit_tick <= 1'b0;
    end else begin
      o_x16_tick <= src_tick && !direct;
      if (direct) begin
        o_bit_tick <= src_tick;
      end else begin
        o_bit_tick <= src_tick && (ovs_cnt == OVS_LAST);
      end
    end
  end
endmodule

// >>> rtl/channel_bit_rate_source_select.sv
// Purpose: bit-rate clock source select for channels a and b
// Assumes: apb slave on i_ref_clk; pins are asynchronous
// Notes: one rate_divider per direction, a tx, a rx, b tx, b rx
// Notes on behaviour
// - command 0A sets transmit extend bit
// - command 08 sets receive extend bit
// - aux msb picks second rate set
// - set two, extends, 88 give 115.2k
// - timer square wave is source over twice count
// - aux mode 110 runs timer from reference
// - nibble D uses timer as 16x
// - output config 01 puts timer on pin three
// - 1x external pins used undivided
// - 16x external clock divided by sixteen
// - generator offers 33 distinct rates
// - nibbles 0 to C use generator
// - low nibble transmit, high nibble receive
// - codes 09 and 0B clear extends
// - divided clock mode halves every generator rate
`timescale 1ns/1ps
module channel_bit_rate_source_select
  import rate_select_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [ADDR_W-1:0] i_paddr,
  input wire logic [DATA_W-1:0] i_pwdata,
  input wire logic i_reference_clock_input,
  input wire logic i_input_pin_three,
  input wire logic i_input_pin_four,
  input wire logic i_input_pin_five,
  input wire logic i_input_pin_six,
  output logic o_pready,
  output logic [DATA_W-1:0] o_prdata,
  output logic o_pslverr,
  output logic o_output_pin_three,
  output logic o_a_tx_x16_tick,
  output logic o_a_tx_bit_tick,
  output logic o_a_rx_x16_tick,
  output logic o_a_rx_bit_tick,
  output logic o_b_tx_x16_tick,
  output logic o_b_rx_x16_tick,
  output logic o_b_tx_bit_tick,
  output logic o_b_rx_bit_tick
);

  // pin synchronisers
  logic [4:0] pin_meta; // first stage, read by pin_sync only
  logic [4:0] pin_sync; // second stage
  logic [4:0] pin_last; // previous synced level
  logic [4:0] pin_rise; // rising edge pulses

  // apb slave
  apb_state_e state; // access phase tracker
  apb_state_e next_state;
  logic wr_en; // write takes effect this edge
  logic [DATA_W-1:0] next_rdata;
  logic next_err;

  // software registers
  logic [7:0] channel_a_clock_select;
  logic [7:0] channel_b_clock_select;
  logic [7:0] aux_control_first;
  logic [7:0] timer_preload_upper;
  logic [7:0] timer_preload_lower;
  logic [7:0] output_pin_config_first;
  logic [7:0] sys_config; // halve and gp output bits

  // extend bits: a rx, a tx, b rx, b tx
  logic a_rx_ext;
  logic a_tx_ext;
  logic b_rx_ext;
  logic b_tx_ext;

  // counter/timer
  logic [15:0] timer_cnt; // down counter
  logic timer_sq; // square wave
  logic timer_sq_last; // for rising edge
  logic timer_rise; // one pulse per period
  logic timer_run; // timer mode selected

  // per-direction wiring, index 0 a tx, 1 a rx, 2 b tx, 3 b rx
  logic [3:0] dir_sel [0:3];
  logic [BRG_DIV_W-1:0] dir_div [0:3];
  logic [3:0] dir_ext;
  logic [3:0] dir_x16;
  logic [3:0] dir_bit;
  logic [3:0] dir_pin_rise;
  logic rate_set; // second set selected

  // input synchronisers, two flops before use
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      pin_meta <= 5'h00;
      pin_sync <= 5'h00;
      pin_last <= 5'h00;
    end else begin
      pin_meta <= {i_input_pin_six, i_input_pin_five, i_input_pin_four,
                   i_input_pin_three, i_reference_clock_input};
      pin_sync <= pin_meta;
      pin_last <= pin_sync;
    end
  end

  // edges are taken after the second stage
  always_comb begin
    pin_rise = pin_sync & ~pin_last;
  end

  // apb state: answer one cycle into the access phase
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        // access phase seen, answer next cycle
        if (i_psel && i_penable) begin
          next_state = ST_RESP;
        end
      end
      ST_RESP: begin
        // pready is high now, transfer ends
        next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // write happens at the edge that samples pready high
  always_comb begin
    wr_en = (state == ST_RESP) && i_psel && i_penable && i_pwrite;
  end

  // state register
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // read mux and address check
  always_comb begin
    next_rdata = '0;
    next_err = 1'b0;
    if (i_paddr == OFS_CMD_A) begin
      // commands are write only, read zero
      next_rdata = '0;
    end else if (i_paddr == OFS_CMD_B) begin
      next_rdata = '0;
    end else if (i_paddr == OFS_AUX) begin
      next_rdata[7:0] = aux_control_first;
    end else if (i_paddr == OFS_CSEL_A) begin
      next_rdata[7:0] = channel_a_clock_select;
    end else if (i_paddr == OFS_CSEL_B) begin
      next_rdata[7:0] = channel_b_clock_select;
    end else if (i_paddr == OFS_TMR_UP) begin
      next_rdata[7:0] = timer_preload_upper;
    end else if (i_paddr == OFS_TMR_LO) begin
      next_rdata[7:0] = timer_preload_lower;
    end else if (i_paddr == OFS_OPCFG) begin
      next_rdata[7:0] = output_pin_config_first;
    end else if (i_paddr == OFS_SYSCFG) begin
      next_rdata[7:0] = sys_config;
    end else if (i_paddr == OFS_STATUS) begin
      // live state of extends, timer and clock pins
      next_rdata[STAT_EXT_LO +: 4] = dir_ext;
      next_rdata[STAT_TIMER] = timer_sq;
      next_rdata[STAT_PIN_LO +: 4] = pin_sync[4:1];
    end else begin
      // unmapped address
      next_err = 1'b1;
    end
  end

  // apb answer outputs, all registered
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_pready <= 1'b0;
      o_prdata <= '0;
      o_pslverr <= 1'b0;
    end else if (state == ST_IDLE && i_psel && i_penable) begin
      // present the answer with pready
      o_pready <= 1'b1;
      o_pslverr <= next_err;
      if (!i_pwrite) begin
        o_prdata <= next_rdata;
      end else begin
        o_prdata <= '0;
      end
    end else begin
      // drop the answer after one cycle
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata <= '0;
    end
  end

  // clock-select registers
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      channel_a_clock_select <= REG8_RST;
      channel_b_clock_select <= REG8_RST;
    end else if (wr_en) begin
      if (i_paddr == OFS_CSEL_A) begin
        channel_a_clock_select <= i_pwdata[7:0];
      end else if (i_paddr == OFS_CSEL_B) begin
        channel_b_clock_select <= i_pwdata[7:0];
      end
    end
  end

  // aux, output config and system config registers
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      aux_control_first <= REG8_RST;
      output_pin_config_first <= REG8_RST;
      sys_config <= REG8_RST;
    end else if (wr_en) begin
      if (i_paddr == OFS_AUX) begin
        aux_control_first <= i_pwdata[7:0];
      end else if (i_paddr == OFS_OPCFG) begin
        output_pin_config_first <= i_pwdata[7:0];
      end else if (i_paddr == OFS_SYSCFG) begin
        sys_config <= i_pwdata[7:0];
      end
    end
  end

  // timer preload registers
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      timer_preload_upper <= REG8_RST;
      timer_preload_lower <= REG8_RST;
    end else if (wr_en) begin
      if (i_paddr == OFS_TMR_UP) begin
        timer_preload_upper <= i_pwdata[7:0];
      end else if (i_paddr == OFS_TMR_LO) begin
        timer_preload_lower <= i_pwdata[7:0];
      end
    end
  end

  // extend bits, channel a commands
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      a_rx_ext <= 1'b0;
      a_tx_ext <= 1'b0;
    end else if (wr_en && i_paddr == OFS_CMD_A) begin
      if (i_pwdata[7:0] == CMD_SET_TX_EXT) begin
        a_tx_ext <= 1'b1;
      end else if (i_pwdata[7:0] == CMD_SET_RX_EXT) begin
        a_rx_ext <= 1'b1;
      end else if (i_pwdata[7:0] == CMD_CLR_RX_EXT) begin
        a_rx_ext <= 1'b0;
      end else if (i_pwdata[7:0] == CMD_CLR_TX_EXT) begin
        a_tx_ext <= 1'b0;
      end
    end
  end

  // extend bits, channel b commands
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      b_rx_ext <= 1'b0;
      b_tx_ext <= 1'b0;
    end else if (wr_en && i_paddr == OFS_CMD_B) begin
      if (i_pwdata[7:0] == CMD_SET_TX_EXT) begin
        b_tx_ext <= 1'b1;
      end else if (i_pwdata[7:0] == CMD_SET_RX_EXT) begin
        b_rx_ext <= 1'b1;
      end else if (i_pwdata[7:0] == CMD_CLR_RX_EXT) begin
        b_rx_ext <= 1'b0;
      end else if (i_pwdata[7:0] == CMD_CLR_TX_EXT) begin
        b_tx_ext <= 1'b0;
      end
    end
  end

  // timer mode decode
  always_comb begin
    timer_run = (aux_control_first[AUX_MODE_HI:AUX_MODE_LO] == MODE_TIMER_REF);
    timer_rise = timer_sq && !timer_sq_last;
  end

  // counter/timer: toggle every preload count of reference edges
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      timer_cnt <= 16'h0000;
      timer_sq <= 1'b0;
    end else if (!timer_run) begin
      // stopped: hold preload, output low
      timer_cnt <= {timer_preload_upper, timer_preload_lower};
      timer_sq <= 1'b0;
    end else if (pin_rise[0]) begin
      if ({timer_preload_upper, timer_preload_lower} == 16'h0000) begin
        // zero preload holds the wave still
        timer_sq <= timer_sq;
      end else if (timer_cnt <= 16'h0001) begin
        // half period done, reload and toggle
        timer_cnt <= {timer_preload_upper, timer_preload_lower};
        timer_sq <= !timer_sq;
      end else begin
        timer_cnt <= timer_cnt - 16'h0001;
      end
    end
  end

  // previous timer level for edge pulse
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      timer_sq_last <= 1'b0;
    end else begin
      timer_sq_last <= timer_sq;
    end
  end

  // output pin three: timer wave or general-purpose level
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_output_pin_three <= 1'b0;
    end else if (output_pin_config_first[OPCFG_HI:OPCFG_LO] == OPCFG_TIMER) begin
      o_output_pin_three <= timer_sq;
    end else begin
      o_output_pin_three <= sys_config[SYSCFG_GP_OUT];
    end
  end

  // per-direction select nibbles, extends and pins
  always_comb begin
    rate_set = aux_control_first[AUX_SET_BIT];
    dir_sel[0] = channel_a_clock_select[3:0];
    dir_sel[1] = channel_a_clock_select[7:4];
    dir_sel[2] = channel_b_clock_select[3:0];
    dir_sel[3] = channel_b_clock_select[7:4];
    dir_ext = {b_rx_ext, b_tx_ext, a_rx_ext, a_tx_ext};
    // 1x data must be kept synchronous by the far end
    dir_pin_rise = pin_rise[4:1];
  end

  // generator table lookup per direction
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      dir_div[i] = BRG_DIV[{rate_set, dir_ext[i], dir_sel[i]}];
    end
  end

  // one divider per direction
  generate
    for (genvar d = 0; d < 4; d++) begin : g_dir
      rate_divider u_div (
        .i_ref_clk(i_ref_clk),
        .i_nrst(i_nrst),
        .i_sel(dir_sel[d]),
        .i_div(dir_div[d]),
        .i_halve(sys_config[SYSCFG_HALVE]),
        .i_ref_rise(pin_rise[0]),
        .i_timer_rise(timer_rise),
        .i_ext_rise(dir_pin_rise[d]),
        .o_x16_tick(dir_x16[d]),
        .o_bit_tick(dir_bit[d])
      );
    end
  endgenerate

  // tick outputs come from divider flops
  assign o_a_tx_x16_tick = dir_x16[0];
  assign o_a_tx_bit_tick = dir_bit[0];
  assign o_a_rx_x16_tick = dir_x16[1];
  assign o_a_rx_bit_tick = dir_bit[1];
  assign o_b_tx_x16_tick = dir_x16[2];
  assign o_b_tx_bit_tick = dir_bit[2];
  assign o_b_rx_x16_tick = dir_x16[3];
  assign o_b_rx_bit_tick = dir_bit[3];

endmodule

// >>> test/rate_select_chk.sv
// Purpose: port checker for the bit-rate source select block
// Assumes: single clock domain, apb slave with one wait state
// Notes: attached to the design top by bind at the foot
`timescale 1ns/1ps
module rate_select_chk
  import rate_select_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic o_pready,
  input wire logic [DATA_W-1:0] o_prdata,
  input wire logic o_pslverr,
  input wire logic o_a_tx_x16_tick,
  input wire logic o_b_rx_bit_tick
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_nrst);
  // first cycle of an access phase
  sequence access_open;
    i_psel && $rose(i_penable);
  endsequence
  // slave completes the transfer
  sequence answered;
    o_pready && i_psel && i_penable;
  endsequence
  ready_wait_a: assert property (access_open |=> answered)
    else $error("ready not given in second access cycle");
  ready_in_access_a: assert property (o_pready |-> ($past(i_psel && i_penable) and answered))
    else $error("ready outside an access phase");
  ready_pulse_a: assert property (o_pready |=> !o_pready)
    else $error("ready held longer than one cycle");
  err_with_ready_a: assert property (o_pslverr |-> o_pready)
    else $error("error flag without ready");
  rdata_idle_a: assert property (!o_pready |-> o_prdata == '0)
    else $error("read data not zero while idle");
  rdata_upper_a: assert property (o_pready |-> o_prdata[DATA_W-1:9] == '0)
    else $error("unused read data bits set");
  x16_pulse_a: assert property (o_a_tx_x16_tick |=> !o_a_tx_x16_tick)
    else $error("oversample tick wider than one cycle");
  bit_pulse_a: assert property (o_b_rx_bit_tick |=> !o_b_rx_bit_tick)
    else $error("bit tick wider than one cycle");
endmodule

bind channel_bit_rate_source_select rate_select_chk rate_select_chk_i (
  .i_ref_clk(i_ref_clk),
  .i_nrst(i_nrst),
  .i_psel(i_psel),
  .i_penable(i_penable),
  .o_pready(o_pready),
  .o_prdata(o_prdata),
  .o_pslverr(o_pslverr),
  .o_a_tx_x16_tick(o_a_tx_x16_tick),
  .o_b_rx_bit_tick(o_b_rx_bit_tick)
);

// >>> test/clock_source_model.sv
// Purpose: reference oscillator and external clock sources
// Assumes: both unrelated in phase to the bench clock
// Notes: external clock rests low while not running
`timescale 1ns/1ps
module clock_source_model #(
  parameter real REF_HALF_NS = 136.0,
  parameter real EXT_HALF_NS = 500.0
) (
  input wire logic i_ext_run,
  output logic o_ref_pin,
  output logic o_ext_pin
);
  // free running oscillator at the reference pin
  initial begin
    o_ref_pin = 1'b0;
    #17;
    forever begin
      #(REF_HALF_NS) o_ref_pin = ~o_ref_pin;
    end
  end
  // steady external clock, still outside use
  initial begin
    o_ext_pin = 1'b0;
    #31;
    forever begin
      #(EXT_HALF_NS) o_ext_pin = i_ext_run ? ~o_ext_pin : 1'b0;
    end
  end
endmodule

// >>> test/channel_bit_rate_source_select_tb.sv
// Purpose: self-checking bench for the bit-rate source select block
// Assumes: apb answers by pready, pins driven by the clock model
// Notes: periods are measured between tick pulses in ns
`timescale 1ns/1ps
module channel_bit_rate_source_select_tb;
  import rate_select_pkg::*;
  localparam real REF_NS = 272.0; // reference pin period
  localparam real EXT_NS = 1000.0; // external pin period
  logic ref_clk = 1'b0; // block clock
  logic nrst = 1'b0; // active low reset
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [DATA_W-1:0] pwdata = '0;
  logic ext_run = 1'b0; // external clock enable
  wire ref_pin; // reference pin
  wire ext_pin; // shared external clock pin
  wire pready;
  wire [DATA_W-1:0] prdata;
  wire pslverr;
  wire [8:0] mon; // ticks plus pin three
  int failures = 0;
  int num_checks = 0;
  // 20 MHz clock
  always begin
    #25 ref_clk = ~ref_clk;
  end
  clock_source_model clock_source_model_i (
    .i_ext_run(ext_run), .o_ref_pin(ref_pin), .o_ext_pin(ext_pin));
  channel_bit_rate_source_select channel_bit_rate_source_select_i (
    .i_ref_clk(ref_clk), .i_nrst(nrst), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .i_reference_clock_input(ref_pin), .i_input_pin_three(ext_pin),
    .i_input_pin_four(ext_pin), .i_input_pin_five(ext_pin), .i_input_pin_six(ext_pin),
    .o_pready(pready), .o_prdata(prdata), .o_pslverr(pslverr),
    .o_output_pin_three(mon[8]), .o_a_tx_x16_tick(mon[0]), .o_a_tx_bit_tick(mon[1]),
    .o_a_rx_x16_tick(mon[2]), .o_a_rx_bit_tick(mon[3]), .o_b_tx_x16_tick(mon[4]),
    .o_b_tx_bit_tick(mon[5]), .o_b_rx_x16_tick(mon[6]), .o_b_rx_bit_tick(mon[7]));
  // counts and verdict, ends the run
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // exact compare of a value
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  // one apb transfer, held until pready is sampled
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    int n = 0;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      failures++;
      $display("mismatch pready expected 1 seen timeout");
      print_verdict();
    end
  endtask
  // register write, expects no error
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic err;
    apb(1'b1, a, d, rd, err);
    chk("write error", 32'h0, {31'h0, err});
  endtask
  // register read compared with expectation
  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp,
                        input logic exp_err);
    logic [31:0] rd;
    logic err;
    apb(1'b0, a, 32'h0, rd, err);
    chk(what, exp, rd);
    chk("read error", {31'h0, exp_err}, {31'h0, err});
  endtask
  // time between second and third rising edge of a monitored line
  task automatic period_chk(input string what, input int idx, input real exp_ns);
    real t0 = 0.0;
    real dt;
    int seen = 0;
    int n = 0;
    logic prev = 1'b1;
    while (seen < 3 && n < 40000) begin
      @(posedge ref_clk);
      n++;
      if (mon[idx] === 1'b1 && prev === 1'b0) begin
        seen++;
        if (seen == 2) t0 = $realtime;
      end
      prev = mon[idx];
    end
    if (seen < 3) begin
      failures++;
      $display("mismatch %s expected edges seen timeout", what);
      print_verdict();
    end else begin
      dt = $realtime - t0;
      num_checks++;
      if (dt > exp_ns + 120.0 || dt < exp_ns - 120.0) begin
        failures++;
        $display("mismatch %s expected %0.1f seen %0.1f", what, exp_ns, dt);
      end
    end
  endtask
  // reset values, write masking, unmapped place
  task automatic s_regs;
    rd_chk("aux reset", OFS_AUX, 32'h0, 1'b0);
    rd_chk("csel a reset", OFS_CSEL_A, 32'h0, 1'b0);
    wr(OFS_CSEL_B, 32'h1234_56A5);
    rd_chk("csel b masked", OFS_CSEL_B, 32'h0000_00A5, 1'b0);
    rd_chk("unmapped", 8'h40, 32'h0, 1'b1);
  endtask
  // generator, extend commands, rate set, halving
  task automatic s_gen;
    wr(OFS_CMD_A, {24'h0, CMD_SET_TX_EXT});
    wr(OFS_CMD_A, {24'h0, CMD_SET_RX_EXT});
    wr(OFS_CMD_B, {24'h0, CMD_SET_TX_EXT});
    rd_chk("extends set", OFS_STATUS, 32'h0000_0007, 1'b0);
    wr(OFS_CMD_B, {24'h0, CMD_CLR_TX_EXT});
    rd_chk("cmd reads zero", OFS_CMD_A, 32'h0, 1'b0);
    wr(OFS_AUX, 32'h0000_0080);
    wr(OFS_CSEL_A, 32'h0000_0088);
    period_chk("a tx 115k2", 1, 32.0 * REF_NS);
    period_chk("a tx x16", 0, 2.0 * REF_NS);
    period_chk("a rx 115k2", 3, 32.0 * REF_NS);
    wr(OFS_SYSCFG, 32'h0000_0003);
    period_chk("a tx halved", 1, 64.0 * REF_NS);
    chk("pin three level", 32'h1, {31'h0, mon[8]});
    wr(OFS_SYSCFG, 32'h0);
    wr(OFS_CMD_A, {24'h0, CMD_CLR_RX_EXT});
    rd_chk("extends cleared", OFS_STATUS, 32'h0000_0001, 1'b0);
    period_chk("a rx no extend", 3, 16.0 * real'(BRG_DIV[6'h28]) * REF_NS);
    period_chk("a tx kept", 1, 32.0 * REF_NS);
  endtask
  // counter/timer as 16x source and on pin three
  task automatic s_timer;
    wr(OFS_TMR_UP, 32'h0);
    wr(OFS_TMR_LO, 32'h0000_0002);
    wr(OFS_AUX, 32'h0000_0060);
    wr(OFS_OPCFG, 32'h0000_0004);
    period_chk("pin three wave", 8, 4.0 * REF_NS);
    wr(OFS_CSEL_B, 32'h0000_00DD);
    period_chk("b tx timer", 5, 64.0 * REF_NS);
    period_chk("b tx x16 timer", 4, 4.0 * REF_NS);
    period_chk("b rx x16 timer", 6, 4.0 * REF_NS);
    period_chk("b rx timer", 7, 64.0 * REF_NS);
  endtask
  // external pins as 1x and 16x clocks
  task automatic s_ext;
    ext_run = 1'b1;
    wr(OFS_CSEL_A, 32'h0000_00FF);
    period_chk("a tx 1x", 1, EXT_NS);
    period_chk("a rx 1x", 3, EXT_NS);
    wr(OFS_CSEL_B, 32'h0000_00FF);
    period_chk("b rx 1x", 7, EXT_NS);
    wr(OFS_CSEL_A, 32'h0000_00EE);
    period_chk("a tx 16x", 1, 16.0 * EXT_NS);
    period_chk("a rx 16x", 3, 16.0 * EXT_NS);
    period_chk("a rx x16 ext", 2, EXT_NS);
    ext_run = 1'b0;
  endtask
  // main sequence
  initial begin
    repeat (8) @(posedge ref_clk);
    nrst <= 1'b1;
    s_regs();
    s_gen();
    s_timer();
    s_ext();
    print_verdict();
  end
endmodule
